// File: bench/cidr_pin_host.sv
// Host model that drives the control pins.
`timescale 1ns/10ps
module cidr_pin_host (
  input wire logic       clk_sys,
  output logic     [4:0] pin
);
  initial pin = 5'h01;
  // Each level is held for the whole count it is given.
  task automatic hold(input int p, input logic v, input int n);
    @(negedge clk_sys);
    pin[p] = v;
    repeat (n) @(negedge clk_sys);
  endtask
endmodule

// File: bench/cidr_properties.sv
// Port-level properties of the control input block, bound to its top level.
`timescale 1ns/10ps
module cidr_properties #(
  parameter int WDT_STEP_CYCLES = 8000
) (
  input wire logic       clk_sys,
  input wire logic       rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       watchdog_reset_pin,
  input wire logic       enable_pin,
  input wire logic       watchdog_reset_n,
  input wire logic       enable_ctl
);
  localparam int EN_MAX  = 9616;
  localparam int WDT_MAX = 64 * WDT_STEP_CYCLES + 16;
  int en_q;
  int wd_q;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // Cycles since the enable and watchdog reset pins last moved; a filtered level may only follow a settled pin.
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      en_q <= 0;
      wd_q <= 0;
    end
    else
    begin
      en_q <= $changed(enable_pin) ? 0 : en_q + 1;
      wd_q <= $changed(watchdog_reset_pin) ? 0 : wd_q + 1;
    end
  end
  AST_WDT_RSV: assert property (reg_rd && reg_addr == 8'h0e |=> reg_rdata[7:3] == 5'h00)
    else $error("upper filter bits read back");
  AST_UNMAPPED: assert property (reg_rd && !(reg_addr inside {[8'h0e:8'h11]}) |=>
    reg_rdata == 8'h00) else $error("unmapped read not zero");
  AST_READBACK: assert property (reg_wr && reg_addr inside {8'h0f, 8'h10, 8'h11} ##1
    reg_rd && !reg_wr && $stable(reg_addr) |=> reg_rdata == $past(reg_wdata, 2))
    else $error("written byte not read back");
  AST_EN_SETTLED: assert property ($changed(enable_ctl) |-> en_q inside {[2:EN_MAX]})
    else $error("enable level moved outside its filter time");
  AST_WDT_SETTLED: assert property ($changed(watchdog_reset_n) |->
    wd_q inside {[2:WDT_MAX]}) else $error("watchdog level moved outside its filter time");
  cover property ($fell(watchdog_reset_n));
  cover property ($rose(enable_ctl));
  cover property (reg_rd && reg_addr == 8'h12);
endmodule
bind cidr_top cidr_properties #(.WDT_STEP_CYCLES(WDT_STEP_CYCLES)) u_prop (.clk_sys, .rst_n,
  .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .watchdog_reset_pin, .enable_pin,
  .watchdog_reset_n, .enable_ctl);

// File: bench/tb.sv
// Self-checking bench for the control input block.
`timescale 1ns/10ps
module tb;
  localparam int W = 8;
  logic        clk_sys, rst_n, reg_wr, reg_rd;
  logic        watchdog_reset_n, enable_ctl, low_power_ctl;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata;
  logic [4:0]  pin;
  logic [12:0] rv;
  logic [31:0] rs = 32'h1;
  int          err_total, samples_checked, m[4];
  wire  [3:0]  ov = {rv[3], low_power_ctl, enable_ctl, watchdog_reset_n};
  cidr_top #(.WDT_STEP_CYCLES(W)) i_dut (.*, .watchdog_reset_pin(pin[0]), .enable_pin(pin[1]),
    .low_power_pin(pin[2]), .general_input_zero(pin[3]), .general_input_one(pin[4]),
    .global_enable_ctl(rv[0]), .master1_enable_ctl(rv[1]), .master2_enable_ctl(rv[2]),
    .master3_enable_ctl(rv[3]), .master4_enable_ctl(rv[4]), .global_voltage_pick(rv[5]),
    .master1_voltage_pick(rv[6]), .master2_voltage_pick(rv[7]), .master3_voltage_pick(rv[8]),
    .master4_voltage_pick(rv[9]), .global_low_power_ctl(rv[10]),
    .master1_low_power_ctl(rv[11]), .master2_low_power_ctl(rv[12]));
  cidr_pin_host i_host (.clk_sys(clk_sys), .pin(pin));
  task automatic chk(input string n, input logic [12:0] s, e);
    samples_checked++;
    if (s !== e)
    begin
      err_total++;
      $display("CHECK FAILED %s exp %h seen %h", n, e, s);
    end
  endtask
  task automatic test_done();
    if (err_total == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  function automatic logic [7:0] xs();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs[7:0];
  endfunction
  function automatic int dn(int p, int c);
    if (p != 0)
      return c * 640;
    if (c == 0)
      return 0;
    return (c == 7 ? 64 : 1 << (c - 1)) * W;
  endfunction
  // Each strobe stands for exactly one rising edge and is lowered again, so a write is a
  // single pulse even when pin activity follows; a read asked for with a write comes in
  // the very next cycle, which is the back-to-back order the register port allows.
  task automatic acc(input logic [7:0] a, d, input logic w, r);
    logic [12:0] ex;
    @(negedge clk_sys);
    reg_addr = a;
    reg_wdata = d;
    if (w)
    begin
      reg_wr = 1'h1;
      if (a > 8'h0d && a < 8'h12)
        m[a - 14] = (a == 8'h0e) ? d & 8'h07 : d;
      @(negedge clk_sys);
      reg_wr = 1'h0;
    end
    if (r)
    begin
      reg_rd = 1'h1;
      @(negedge clk_sys);
      reg_rd = 1'h0;
      ex = (a > 8'h0d && a < 8'h12) ? 13'(m[a - 14]) : 13'h0;
      chk("rdata", 13'(reg_rdata), ex);
    end
  endtask
  task automatic wr(input logic [7:0] a, d);
    acc(a, d, 1'h1, 1'h0);
  endtask
  task automatic rd(input logic [7:0] a);
    acc(a, 8'h00, 1'h0, 1'h1);
  endtask
  task automatic tdeb(input int p, n, input logic v);
    if (n >= 20)
    begin
      i_host.hold(p, v, n - 10);
      i_host.hold(p, !v, n + 10);
      chk("short", 13'(ov[p]), 13'(!v));
    end
    i_host.hold(p, v, n);
    chk("early", 13'(ov[p]), 13'(!v));
    i_host.hold(p, v, 10);
    chk("late", 13'(ov[p]), 13'(v));
  endtask
  initial
  begin
    clk_sys = 1'h0;
    forever #50 clk_sys = ~clk_sys;
  end
  initial
  begin
    repeat (90000) @(posedge clk_sys);
    err_total++;
    test_done();
  end
  initial
  begin
    rst_n = 1'h0;
    reg_wr = 1'h0;
    reg_rd = 1'h0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    m = '{8'h02, 8'h43, 8'h11, 8'h11};
    repeat (5) @(negedge clk_sys);
    rst_n = 1'h1;
    for (int a = 13; a < 19; a++)
      rd(8'(a));
    wr(8'h10, 8'h18);
    for (int p = 1; p < 4; p++)
      for (int v = 1; v >= 0; v--)
        tdeb(p, dn(p, p == 1 ? 8 : 1), v[0]);
    for (int c = 0; c < 8; c++)
    begin
      wr(8'h0e, 8'(c));
      tdeb(0, dn(0, c), 1'h0);
      tdeb(0, dn(0, c), 1'h1);
    end
    for (int a = 13; a < 19; a++)
    begin
      acc(8'(a), xs(), 1'h1, 1'h1);
    end
    wr(8'h11, 8'h00);
    for (int c = 0; c < 16; c++)
    begin
      wr(8'h0f, {4'(15 - c), 4'(c)});
      i_host.hold(3, 1'h1, 0);
      i_host.hold(4, 1'h1, 12);
      chk("route", rv, 13'((32'h1 << c) | (32'h1 << (15 - c))));
      i_host.hold(3, 1'h0, 0);
      i_host.hold(4, 1'h0, 12);
      chk("route", rv, 13'h0);
    end
    test_done();
  end
endmodule

// File: rtl/cidr_filt_if.sv
// Connection between the top level and one debounce filter.
`timescale 1ns/10ps
interface cidr_filt_if;
  logic [cidr_pkg::STEPS_W-1:0] steps;
  logic                         level_in;
  logic                         level_out;

  modport ctl (output steps, output level_in, input level_out);
  modport flt (input steps, input level_in, output level_out);
endinterface

// File: rtl/cidr_filter.sv
// Debounce filter that accepts a new level after it has held for a number of steps.
`timescale 1ns/10ps
module cidr_filter #(
  parameter int   STEP_CYCLES = cidr_pkg::GEN_STEP_CYCLES,
  parameter logic RESET_LEVEL = 1'b0
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  cidr_filt_if.flt f
);

  logic [cidr_pkg::CYC_W-1:0]   cyc;
  logic [cidr_pkg::STEPS_W-1:0] step_cnt;
  logic                         level;

  wire differs   = f.level_in != level;
  wire step_done = cyc == cidr_pkg::CYC_W'(STEP_CYCLES - 1);
  // Compared as at-least so that a code shortened in mid-count ends the wait when the current step completes
  // instead of running the step counter all the way round.
  wire all_done  = step_cnt >= f.steps - 1'b1;

  assign f.level_out = level;

  // The step counters restart on every mismatch gap, so the new level must hold
  // without a break for the whole time; a glitch back to the old level wipes progress.
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cyc      <= '0;
      step_cnt <= '0;
      level    <= RESET_LEVEL;
    end
    else if (!differs)
    begin
      cyc      <= '0;
      step_cnt <= '0;
    end
    else if (f.steps == '0)
    begin
      level <= f.level_in;
    end
    else if (step_done)
    begin
      cyc <= '0;
      if (all_done)
      begin
        level    <= f.level_in;
        step_cnt <= '0;
      end
      else
      begin
        step_cnt <= step_cnt + 1'b1;
      end
    end
    else
    begin
      cyc <= cyc + 1'b1;
    end
  end

endmodule

// File: rtl/cidr_pkg.sv
// Constants for the control input debounce and routing block.
// What this block does
// - Watchdog reset input filtered, 3-bit time code.
// - Each general input routed by 4-bit selector.
// - Enable, low-power inputs filtered in 64 us steps.
// - General inputs filtered, code times 64 us.
package cidr_pkg;

  localparam logic [7:0] ADDR_WDT_FILT   = 8'h0e;
  localparam logic [7:0] ADDR_ROUTE      = 8'h0f;
  localparam logic [7:0] ADDR_EN_LP_FILT = 8'h10;
  localparam logic [7:0] ADDR_GEN_FILT   = 8'h11;

  localparam logic [7:0] RST_WDT_FILT    = 8'h02;
  localparam logic [7:0] RST_ROUTE       = 8'h43;
  localparam logic [7:0] RST_EN_LP_FILT  = 8'h11;
  localparam logic [7:0] RST_GEN_FILT    = 8'h11;

  localparam int WDT_CODE_W = 3;
  localparam int NIB_W      = 4;
  localparam int NIB_LO     = 0;
  localparam int NIB_HI     = 4;

  localparam int CLK_PERIOD_NS = 100;
  localparam int WDT_STEP_NS   = 800000;
  localparam int GEN_STEP_NS   = 64000;
  localparam int WDT_STEP_CYCLES = (WDT_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int GEN_STEP_CYCLES = (GEN_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam int STEPS_W = 8;
  localparam int CYC_W   = 14;
  localparam int NUM_PINS = 5;
  localparam int PIN_WDT  = 0;
  localparam int PIN_EN   = 1;
  localparam int PIN_LP   = 2;
  localparam int PIN_GENERAL_INPUT_ZERO = 3;
  localparam int PIN_GENERAL_INPUT_ONE = 4;

  localparam int NUM_CTL = 13;

endpackage

// File: rtl/cidr_top.sv
// Control pin conditioning: settings registers, debounce filters and input routing.
`timescale 1ns/10ps
module cidr_top #(
  parameter int WDT_STEP_CYCLES = cidr_pkg::WDT_STEP_CYCLES
) (
  input  wire logic       clk_sys,
  input  wire logic       rst_n,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  input  wire logic       watchdog_reset_pin,
  input  wire logic       enable_pin,
  input  wire logic       low_power_pin,
  input  wire logic       general_input_zero,
  input  wire logic       general_input_one,
  output logic            watchdog_reset_n,
  output logic            enable_ctl,
  output logic            low_power_ctl,
  output logic            global_enable_ctl,
  output logic            master1_enable_ctl,
  output logic            master2_enable_ctl,
  output logic            master3_enable_ctl,
  output logic            master4_enable_ctl,
  output logic            global_voltage_pick,
  output logic            master1_voltage_pick,
  output logic            master2_voltage_pick,
  output logic            master3_voltage_pick,
  output logic            master4_voltage_pick,
  output logic            global_low_power_ctl,
  output logic            master1_low_power_ctl,
  output logic            master2_low_power_ctl
);

  localparam int N = cidr_pkg::NUM_PINS;
  localparam int C = cidr_pkg::NUM_CTL;

  // Selector codes 0000 to 1100 map onto control bits 0 to 12 in order.
  // Codes 1101 to 1111 drive nothing.
  function automatic logic [C-1:0] route_hit(input logic [3:0] sel);
    logic [C-1:0] hit;
    hit = '0;
    if (sel < 4'(C))
    begin
      hit[sel] = 1'b1;
    end
    return hit;
  endfunction

  // 3-bit code: 0 is off, otherwise 2^(code-1) steps of 0.8 ms. Code 110 gives
  // 25.6 ms, the value the doubling pattern implies.
  function automatic logic [cidr_pkg::STEPS_W-1:0] wdt_steps(input logic [2:0] code);
    logic [cidr_pkg::STEPS_W-1:0] s;
    s = '0;
    if (code != 3'h0)
    begin
      s = cidr_pkg::STEPS_W'(1) << (code - 3'h1);
    end
    return s;
  endfunction

  logic [2:0] wdt_code;
  logic [7:0] route;
  logic [7:0] en_lp_code;
  logic [7:0] gen_code;

  wire [3:0] input_zero_route      = route[cidr_pkg::NIB_LO +: cidr_pkg::NIB_W];
  wire [3:0] input_one_route       = route[cidr_pkg::NIB_HI +: cidr_pkg::NIB_W];
  wire [3:0] enable_filter_code    = en_lp_code[cidr_pkg::NIB_LO +: cidr_pkg::NIB_W];
  wire [3:0] low_power_filter_code = en_lp_code[cidr_pkg::NIB_HI +: cidr_pkg::NIB_W];
  wire [3:0] input_zero_filter_code = gen_code[cidr_pkg::NIB_LO +: cidr_pkg::NIB_W];
  wire [3:0] input_one_filter_code  = gen_code[cidr_pkg::NIB_HI +: cidr_pkg::NIB_W];

  wire hit_wdt   = reg_addr == cidr_pkg::ADDR_WDT_FILT;
  wire hit_route = reg_addr == cidr_pkg::ADDR_ROUTE;
  wire hit_enlp  = reg_addr == cidr_pkg::ADDR_EN_LP_FILT;
  wire hit_gen   = reg_addr == cidr_pkg::ADDR_GEN_FILT;

  wire [7:0] rd_mux = hit_wdt   ? {5'h00, wdt_code} :
                      hit_route ? route :
                      hit_enlp  ? en_lp_code :
                      hit_gen   ? gen_code : 8'h00;

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wdt_code   <= cidr_pkg::RST_WDT_FILT[2:0];
      route      <= cidr_pkg::RST_ROUTE;
      en_lp_code <= cidr_pkg::RST_EN_LP_FILT;
      gen_code   <= cidr_pkg::RST_GEN_FILT;
      reg_rdata  <= 8'h00;
    end
    else
    begin
      if (reg_wr && hit_wdt)
      begin
        wdt_code <= reg_wdata[cidr_pkg::WDT_CODE_W-1:0];
      end
      if (reg_wr && hit_route)
      begin
        route <= reg_wdata;
      end
      if (reg_wr && hit_enlp)
      begin
        en_lp_code <= reg_wdata;
      end
      if (reg_wr && hit_gen)
      begin
        gen_code <= reg_wdata;
      end
      if (reg_rd)
      begin
        reg_rdata <= rd_mux;
      end
    end
  end

  // Pins arrive from outside the clock domain: three flops, and the level
  // moves on only when the second and third flops agree.
  wire  [N-1:0] pin_raw = {general_input_one, general_input_zero, low_power_pin,
                           enable_pin, watchdog_reset_pin};
  localparam logic [N-1:0] PIN_IDLE = 5'h01;
  logic [N-1:0] sync1;
  logic [N-1:0] sync2;
  logic [N-1:0] sync3;
  logic [N-1:0] pin_agreed;
  logic [N-1:0] filtered;

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sync1      <= PIN_IDLE;
      sync2      <= PIN_IDLE;
      sync3      <= PIN_IDLE;
      pin_agreed <= PIN_IDLE;
    end
    else
    begin
      sync1 <= pin_raw;
      sync2 <= sync1;
      sync3 <= sync2;
      pin_agreed <= (sync2 & sync3) | (pin_agreed & (sync2 ^ sync3));
    end
  end

  wire [cidr_pkg::STEPS_W-1:0] steps_sel [N];
  assign steps_sel[cidr_pkg::PIN_WDT]  = wdt_steps(wdt_code);
  assign steps_sel[cidr_pkg::PIN_EN]   = cidr_pkg::STEPS_W'(enable_filter_code);
  assign steps_sel[cidr_pkg::PIN_LP]   = cidr_pkg::STEPS_W'(low_power_filter_code);
  assign steps_sel[cidr_pkg::PIN_GENERAL_INPUT_ZERO] = cidr_pkg::STEPS_W'(input_zero_filter_code);
  assign steps_sel[cidr_pkg::PIN_GENERAL_INPUT_ONE] = cidr_pkg::STEPS_W'(input_one_filter_code);

  for (genvar i = 0; i < N; i++)
  begin : g_filt
    cidr_filt_if fi ();
    assign fi.steps    = steps_sel[i];
    assign fi.level_in = pin_agreed[i];
    assign filtered[i] = fi.level_out;
    cidr_filter #(
      .STEP_CYCLES (i == cidr_pkg::PIN_WDT ? WDT_STEP_CYCLES : cidr_pkg::GEN_STEP_CYCLES),
      .RESET_LEVEL (PIN_IDLE[i])
    ) u_filt (
      .clk_sys (clk_sys),
      .rst_n   (rst_n),
      .f       (fi.flt)
    );
  end

  // Both inputs may pick the same control; their levels are then ORed.
  wire [C-1:0] next_ctl =
    (filtered[cidr_pkg::PIN_GENERAL_INPUT_ZERO] ? route_hit(input_zero_route) : '0) |
    (filtered[cidr_pkg::PIN_GENERAL_INPUT_ONE] ? route_hit(input_one_route) : '0);
  logic [C-1:0] ctl;
  logic [2:0]   direct;

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctl    <= '0;
      direct <= 3'h1;
    end
    else
    begin
      ctl    <= next_ctl;
      direct <= filtered[2:0];
    end
  end

  assign watchdog_reset_n      = direct[cidr_pkg::PIN_WDT];
  assign enable_ctl            = direct[cidr_pkg::PIN_EN];
  assign low_power_ctl         = direct[cidr_pkg::PIN_LP];
  assign global_enable_ctl     = ctl[0];
  assign master1_enable_ctl    = ctl[1];
  assign master2_enable_ctl    = ctl[2];
  assign master3_enable_ctl    = ctl[3];
  assign master4_enable_ctl    = ctl[4];
  assign global_voltage_pick   = ctl[5];
  assign master1_voltage_pick  = ctl[6];
  assign master2_voltage_pick  = ctl[7];
  assign master3_voltage_pick  = ctl[8];
  assign master4_voltage_pick  = ctl[9];
  assign global_low_power_ctl  = ctl[10];
  assign master1_low_power_ctl = ctl[11];
  assign master2_low_power_ctl = ctl[12];

endmodule
